// >>> logic/mpd_pkg.sv
package mpd_pkg;
    // ----------------------------------------
    // widths and sizes
    // ----------------------------------------
    localparam int WORD_W = 16;
    localparam int UADDR_W = 12;
    localparam int UWORD_W = 64;
    localparam int WCS_AW = 8;
    localparam int OPC_W = 5;
    localparam int DISP_W = 11;
    localparam int PAGE_BITS = 10;
    localparam int LVL_W = 4;
    localparam int REG_AW = 3;
    localparam int NREGS = 8;
    localparam int P_IDX = 7;
    // ----------------------------------------
    // microcycle timing
    // ----------------------------------------
    localparam int CLK_NS = 25;
    localparam int UCYC_FAST_NS = 150;
    localparam int UCYC_SLOW_NS = 190;
    localparam int UCYC_FAST = (UCYC_FAST_NS + CLK_NS - 1) / CLK_NS;
    localparam int UCYC_SLOW = (UCYC_SLOW_NS + CLK_NS - 1) / CLK_NS;
    // ----------------------------------------
    // reset values and map layout
    // ----------------------------------------
    localparam logic [WORD_W-1:0] RESET_PC = 16'h0000;
    localparam logic [UADDR_W-1:0] RESET_UADDR = 12'h000;
    localparam logic [UADDR_W-1:0] MAP_BASE = 12'h000;
    localparam logic [UADDR_W-1:0] MAP_STRIDE = 12'h020;
    localparam logic [OPC_W-1:0] BRANCH_OPC = 5'h1e;
    localparam logic [LVL_W-1:0] RESET_LEVEL = 4'h0;
    // ----------------------------------------
    // types
    // ----------------------------------------
    typedef enum logic [2:0] {BS_NONE, BS_ALU, BS_WREG, BS_RFILE, BS_IR, BS_MDR} mpd_src_t;
    typedef enum logic [1:0] {ALU_ADD, ALU_SUB, ALU_AND, ALU_OR} mpd_aluop_t;
    typedef enum logic [1:0] {F_IDLE, F_WAIT, F_DROP} mpd_fst_t;
    typedef enum logic [1:0] {L_RUN, L_SAVE, L_LOAD} mpd_lst_t;
    typedef struct packed {
        mpd_src_t src;
        logic [REG_AW-1:0] src_idx;
        logic dst_wreg;
        logic dst_rfile;
        logic dst_pc;
        logic [REG_AW-1:0] dst_idx;
        logic [REG_AW-1:0] sel_a;
        logic [REG_AW-1:0] sel_b;
        mpd_aluop_t op;
        logic oper_req;
        logic next_instr;
    } mpd_uctl_t;
    typedef struct packed {
        logic req;
        logic [WORD_W-1:0] addr;
    } mpd_mreq_t;
    typedef struct packed {
        logic we;
        logic [WCS_AW-1:0] addr;
        logic [UWORD_W-1:0] data;
    } mpd_wcs_t;
endpackage : mpd_pkg

// >>> logic/mpd_prefetch_dispatch.sv
`timescale 1ns/1ps
module mpd_prefetch_dispatch
    import mpd_pkg::*;
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_reset,
    // configuration straps
    input wire logic i_mmu_fitted,
    input wire logic i_cache_fitted,
    // microinstruction fields
    input wire mpd_uctl_t i_uctl,
    input wire logic [UADDR_W-1:0] i_next_uaddr,
    input wire logic [UWORD_W-1:0] i_rom_word,
    input wire mpd_wcs_t i_wcs,
    // level change and store watch
    input wire logic i_level_change,
    input wire logic [LVL_W-1:0] i_new_level,
    input wire logic i_store_req,
    input wire logic [WORD_W-1:0] i_store_addr,
    // memory answer
    input wire logic i_mem_ack,
    input wire logic [WORD_W-1:0] i_mem_data,
    // memory requests
    output mpd_mreq_t o_mmu,
    output mpd_mreq_t o_sysbus,
    // sequencer
    output logic [UADDR_W-1:0] o_uaddr,
    output logic [UWORD_W-1:0] o_uinst,
    output logic o_uend,
    output logic o_stall,
    // datapath view
    output logic [DISP_W-1:0] o_ir,
    output logic [WORD_W-1:0] o_bus,
    output logic [LVL_W-1:0] o_level
);

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [UADDR_W-1:0] op_start(input logic [OPC_W-1:0] opc);
        op_start = MAP_BASE + UADDR_W'(opc) * MAP_STRIDE;
    endfunction : op_start

    function automatic logic [LVL_W+REG_AW-1:0] rf_ix(input logic [LVL_W-1:0] lvl,
                                                      input logic [REG_AW-1:0] idx);
        rf_ix = {lvl, idx};
    endfunction : rf_ix

    function automatic logic [WORD_W-1:0] alu_fn(input mpd_aluop_t op,
                                                 input logic [WORD_W-1:0] a,
                                                 input logic [WORD_W-1:0] b);
        unique case (op)
        ALU_ADD: alu_fn = a + b;
        ALU_SUB: alu_fn = a - b;
        ALU_AND: alu_fn = a & b;
        ALU_OR: alu_fn = a | b;
        endcase
    endfunction : alu_fn

    // ----------------------------------------
    // state
    // ----------------------------------------
    mpd_fst_t fst_reg, fst_next;
    mpd_lst_t lst_reg, lst_next;
    mpd_mreq_t mreq_reg, mreq_next, mmu_reg, mmu_next, sys_reg, sys_next;
    logic [1:0] fit_m_reg, fit_reg;
    logic [WORD_W-1:0] pc_reg, pc_next, pf_reg, pf_next, pfa_reg, pfa_next;
    logic [WORD_W-1:0] mdr_reg, mdr_next, alu_reg, alu_next, bus_reg, bus_next;
    logic pfv_reg, pfv_next, oper_reg, oper_next, kind_reg, kind_next;
    logic pend_reg, pend_next, uend_reg, uend_next;
    logic [DISP_W-1:0] ir_reg, ir_next;
    logic [OPC_W-1:0] opc_reg, opc_next;
    logic [UADDR_W-1:0] uaddr_reg, uaddr_next;
    logic [UWORD_W-1:0] uinst_reg, uinst_next, cs_w;
    logic [3:0] cnt_reg, cnt_next;
    logic [LVL_W-1:0] level_reg, level_next, nlev_reg, nlev_next;
    logic [REG_AW-1:0] idx_reg, idx_next;
    logic [WORD_W-1:0] wreg_reg [NREGS], wreg_next [NREGS];
    logic [WORD_W-1:0] rfile_reg [NREGS << LVL_W], rfile_next [NREGS << LVL_W];
    logic [UWORD_W-1:0] wcs_reg [1 << WCS_AW], wcs_next [1 << WCS_AW];
    logic flush, store_hit, hold, fetch_start, want, disp_go;
    logic [WORD_W-1:0] ftarget, bus_w;

    // ----------------------------------------
    // next-state logic
    // ----------------------------------------
    always_comb
    begin
        fst_next = fst_reg;
        lst_next = lst_reg;
        mreq_next = mreq_reg;
        pc_next = pc_reg;
        pf_next = pf_reg;
        pfa_next = pfa_reg;
        mdr_next = mdr_reg;
        alu_next = alu_reg;
        bus_next = bus_reg;
        pfv_next = pfv_reg;
        oper_next = oper_reg;
        kind_next = kind_reg;
        pend_next = pend_reg;
        ir_next = ir_reg;
        opc_next = opc_reg;
        uaddr_next = uaddr_reg;
        uinst_next = uinst_reg;
        level_next = level_reg;
        nlev_next = nlev_reg;
        idx_next = idx_reg;
        wreg_next = wreg_reg;
        rfile_next = rfile_reg;
        wcs_next = wcs_reg;
        flush = 1'b0;
        ftarget = pc_reg;
        bus_w = '0;
        fetch_start = 1'b0;
        // microcycle timer; slow count without cache
        if (cnt_reg == 4'h0)
            cnt_next = fit_reg[1] ? 4'(UCYC_FAST - 1) : 4'(UCYC_SLOW - 1);
        else
            cnt_next = cnt_reg - 4'h1;
        uend_next = (cnt_next == 4'h0);
        // writable control store port
        if (i_wcs.we)
            wcs_next[i_wcs.addr] = i_wcs.data;
        // a store onto the prefetched word: refetch it
        store_hit = i_store_req && (i_store_addr == pfa_reg)
                    && (pfv_reg || (fst_reg == F_WAIT && !kind_reg));
        if (store_hit)
        begin
            flush = 1'b1;
            ftarget = pfa_reg;
        end
        // word bus and register set exchange
        unique case (lst_reg)
        L_RUN:
        begin
            if (uend_reg)
            begin
                // microcode picks at most one driver
                unique case (i_uctl.src)
                BS_NONE: bus_w = '0;
                BS_ALU: bus_w = alu_reg;
                BS_WREG: bus_w = wreg_reg[i_uctl.src_idx];
                BS_RFILE: bus_w = rfile_reg[rf_ix(level_reg, i_uctl.src_idx)];
                BS_IR: bus_w = WORD_W'(ir_reg);
                BS_MDR: bus_w = mdr_reg;
                default: bus_w = '0;
                endcase
                bus_next = bus_w;
                if (i_uctl.dst_wreg)
                    wreg_next[i_uctl.dst_idx] = bus_w;
                if (i_uctl.dst_rfile)
                    rfile_next[rf_ix(level_reg, i_uctl.dst_idx)] = bus_w;
                if (i_uctl.dst_pc)
                begin
                    flush = 1'b1;
                    ftarget = bus_w;
                end
                alu_next = alu_fn(i_uctl.op, wreg_reg[i_uctl.sel_a],
                                  wreg_reg[i_uctl.sel_b]);
                if (i_uctl.oper_req)
                    oper_next = 1'b1;
            end
            if (i_level_change)
            begin
                lst_next = L_SAVE;
                idx_next = '0;
                nlev_next = i_new_level;
                flush = 1'b1;
                ftarget = pc_reg;
            end
        end
        L_SAVE:
        begin
            bus_w = wreg_reg[idx_reg];
            bus_next = bus_w;
            rfile_next[rf_ix(level_reg, idx_reg)] = bus_w;
            idx_next = idx_reg + 3'h1;
            if (idx_reg == 3'(NREGS - 1))
                lst_next = L_LOAD;
        end
        L_LOAD:
        begin
            bus_w = rfile_reg[rf_ix(nlev_reg, idx_reg)];
            bus_next = bus_w;
            wreg_next[idx_reg] = bus_w;
            idx_next = idx_reg + 3'h1;
            if (idx_reg == 3'(NREGS - 1))
            begin
                lst_next = L_RUN;
                level_next = nlev_reg;
                flush = 1'b1;
                ftarget = wreg_next[P_IDX];
            end
        end
        endcase
        // no speculative fetch into a new page behind a branch
        hold = (lst_reg != L_RUN) || flush
               || (opc_reg == BRANCH_OPC && pc_reg[PAGE_BITS-1:0] == '0 && !pend_reg);
        // memory access sequencer
        unique case (fst_reg)
        F_IDLE:
        begin
            if (oper_reg)
            begin
                mreq_next = '{req: 1'b1, addr: alu_reg};
                kind_next = 1'b1;
                oper_next = 1'b0;
                fst_next = F_WAIT;
            end
            else if (!pfv_reg && !hold)
            begin
                fetch_start = 1'b1;
                mreq_next = '{req: 1'b1, addr: pc_reg};
                pfa_next = pc_reg;
                kind_next = 1'b0;
                fst_next = F_WAIT;
            end
        end
        F_WAIT:
        begin
            if (i_mem_ack)
            begin
                mreq_next.req = 1'b0;
                fst_next = F_IDLE;
                if (kind_reg)
                    mdr_next = i_mem_data;
                else
                begin
                    pf_next = i_mem_data;
                    pfv_next = 1'b1;
                    pc_next = pc_reg + 16'h0001;
                end
            end
            else if (flush && !kind_reg)
                fst_next = F_DROP;
        end
        F_DROP:
        begin
            if (i_mem_ack)
            begin
                mreq_next.req = 1'b0;
                fst_next = F_IDLE;
            end
        end
        default: fst_next = F_IDLE;
        endcase
        // discard wins over a word arriving now
        if (flush)
        begin
            pfv_next = 1'b0;
            pc_next = ftarget;
        end
        // instruction start at microcycle end, from prefetch only
        want = pend_reg || (uend_reg && lst_reg == L_RUN && i_uctl.next_instr);
        disp_go = uend_reg && want && pfv_reg && !flush;
        cs_w = uaddr_reg[UADDR_W-1] ? wcs_reg[uaddr_reg[WCS_AW-1:0]] : i_rom_word;
        if (uend_reg)
        begin
            if (disp_go)
            begin
                ir_next = pf_reg[DISP_W-1:0];
                opc_next = pf_reg[WORD_W-1:DISP_W];
                uaddr_next = op_start(pf_reg[WORD_W-1:DISP_W]);
                uinst_next = cs_w;
                pfv_next = 1'b0;
                pend_next = 1'b0;
            end
            else if (want)
            begin
                // stall: issue no-op until prefetch arrives
                pend_next = 1'b1;
                uinst_next = '0;
            end
            else
            begin
                uaddr_next = i_next_uaddr;
                uinst_next = cs_w;
            end
        end
        // route the request by fitted memory manager
        mmu_next = '{req: mreq_next.req && fit_reg[0], addr: mreq_next.addr};
        sys_next = '{req: mreq_next.req && !fit_reg[0], addr: mreq_next.addr};
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    always_ff @(posedge i_clk)
    begin
        // straps pass two flops before use
        fit_m_reg <= {i_cache_fitted, i_mmu_fitted};
        fit_reg <= fit_m_reg;
        // storage arrays carry no reset
        wreg_reg <= wreg_next;
        rfile_reg <= rfile_next;
        wcs_reg <= wcs_next;
        if (i_reset)
        begin
            fst_reg <= F_IDLE;
            lst_reg <= L_RUN;
            mreq_reg <= '0;
            mmu_reg <= '0;
            sys_reg <= '0;
            pc_reg <= RESET_PC;
            pf_reg <= '0;
            pfa_reg <= RESET_PC;
            mdr_reg <= '0;
            alu_reg <= '0;
            bus_reg <= '0;
            pfv_reg <= 1'b0;
            oper_reg <= 1'b0;
            kind_reg <= 1'b0;
            pend_reg <= 1'b0;
            uend_reg <= 1'b0;
            ir_reg <= '0;
            opc_reg <= '0;
            uaddr_reg <= RESET_UADDR;
            uinst_reg <= '0;
            cnt_reg <= 4'h0;
            level_reg <= RESET_LEVEL;
            nlev_reg <= RESET_LEVEL;
            idx_reg <= '0;
        end
        else
        begin
            fst_reg <= fst_next;
            lst_reg <= lst_next;
            mreq_reg <= mreq_next;
            mmu_reg <= mmu_next;
            sys_reg <= sys_next;
            pc_reg <= pc_next;
            pf_reg <= pf_next;
            pfa_reg <= pfa_next;
            mdr_reg <= mdr_next;
            alu_reg <= alu_next;
            bus_reg <= bus_next;
            pfv_reg <= pfv_next;
            oper_reg <= oper_next;
            kind_reg <= kind_next;
            pend_reg <= pend_next;
            uend_reg <= uend_next;
            ir_reg <= ir_next;
            opc_reg <= opc_next;
            uaddr_reg <= uaddr_next;
            uinst_reg <= uinst_next;
            cnt_reg <= cnt_next;
            level_reg <= level_next;
            nlev_reg <= nlev_next;
            idx_reg <= idx_next;
        end
    end

    // outputs straight from flops
    assign o_mmu = mmu_reg;
    assign o_sysbus = sys_reg;
    assign o_uaddr = uaddr_reg;
    assign o_uinst = uinst_reg;
    assign o_uend = uend_reg;
    assign o_stall = pend_reg;
    assign o_ir = ir_reg;
    assign o_bus = bus_reg;
    assign o_level = level_reg;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);

    sequence s_save;
        (lst_reg == L_SAVE) [*8];
    endsequence
    sequence s_load;
        (lst_reg == L_LOAD) [*8];
    endsequence

    bus_to_wreg_a: assert property (uend_reg && lst_reg == L_RUN && !i_level_change
        && i_uctl.dst_wreg && i_uctl.src == BS_ALU
        |=> wreg_reg[$past(i_uctl.dst_idx)] == $past(alu_reg))
        else $error("word bus did not carry alu word");
    oper_addr_a: assert property (fst_reg == F_IDLE && oper_reg
        |=> mreq_reg.req && mreq_reg.addr == $past(alu_reg))
        else $error("operand address not from alu");
    route_a: assert property (o_mmu.req |-> !o_sysbus.req && fit_reg[0])
        else $error("request routed to wrong path");
    fetch_pc_a: assert property (fetch_start
        |=> mreq_reg.req && mreq_reg.addr == $past(pc_reg))
        else $error("fetch address not program counter");
    capture_a: assert property (fst_reg == F_WAIT && i_mem_ack && !kind_reg && !flush
        |=> pfv_reg && pf_reg == $past(i_mem_data))
        else $error("fetched word not captured");
    load_ir_a: assert property (disp_go
        |=> o_ir == $past(pf_reg[DISP_W-1:0]) && !pfv_reg)
        else $error("instruction load not from prefetch");
    map_start_a: assert property (disp_go
        |=> o_uaddr == op_start($past(pf_reg[WORD_W-1:DISP_W])))
        else $error("wrong microprogram start address");
    flush_pf_a: assert property (flush
        |=> !pfv_reg && pc_reg == $past(ftarget))
        else $error("prefetch not discarded");
    page_hold_a: assert property (opc_reg == BRANCH_OPC && pc_reg[PAGE_BITS-1:0] == '0
        && !pend_reg |-> !fetch_start)
        else $error("speculative fetch across page");
    store_refetch_a: assert property (store_hit && !uend_reg
        |=> !pfv_reg && pc_reg == $past(pfa_reg))
        else $error("store onto prefetch not refetched");
    ucycle_gap_a: assert property (o_uend |=> (!o_uend) [*5])
        else $error("microcycle too short");
    cs_pipe_a: assert property (uend_reg && !want && !uaddr_reg[UADDR_W-1]
        |=> o_uinst == $past(i_rom_word) && o_uaddr == $past(i_next_uaddr))
        else $error("control store readout not pipelined");
    wcs_write_a: assert property (i_wcs.we
        |=> wcs_reg[$past(i_wcs.addr)] == $past(i_wcs.data))
        else $error("writable store not written");
    alu_sel_a: assert property (uend_reg && lst_reg == L_RUN
        |=> alu_reg == alu_fn($past(i_uctl.op), $past(wreg_reg[i_uctl.sel_a]),
                              $past(wreg_reg[i_uctl.sel_b])))
        else $error("alu result wrong");
    level_swap_a: assert property (lst_reg == L_RUN && i_level_change
        |=> s_save ##1 s_load ##1 (lst_reg == L_RUN && level_reg == $past(nlev_reg)))
        else $error("register set exchange wrong");

endmodule : mpd_prefetch_dispatch

// >>> verification/mpd_mem_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// memory manager and system bus stand-in
// ----------------------------------------
module mpd_mem_model
    import mpd_pkg::*;
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_reset,
    // requests and answer delay
    input wire mpd_mreq_t i_mmu,
    input wire mpd_mreq_t i_sysbus,
    input wire logic [4:0] i_lat,
    // answer
    output logic o_ack,
    output logic [WORD_W-1:0] o_data
);
    logic [1:0] st_reg;
    logic [4:0] cnt_reg;
    logic [WORD_W-1:0] addr_reg;
    // contents are a fixed scramble of the address
    function automatic logic [WORD_W-1:0] mem_word(input logic [WORD_W-1:0] a);
        return (a * 16'h0025) ^ 16'h5a3c;
    endfunction : mem_word
    initial
    begin
        o_ack = 1'b0;
        o_data = 16'h0000;
    end
    // one access at a time; data wanders off the ack so a stale word never passes
    always @(posedge i_clk)
    begin
        o_ack <= 1'b0;
        o_data <= ~o_data;
        if (i_reset)
            st_reg <= 2'h0;
        else if (st_reg == 2'h0 && (i_mmu.req || i_sysbus.req))
        begin
            st_reg <= 2'h1;
            cnt_reg <= i_lat;
            addr_reg <= i_mmu.req ? i_mmu.addr : i_sysbus.addr;
        end
        else if (st_reg == 2'h1 && cnt_reg != 5'h00)
            cnt_reg <= cnt_reg - 5'h01;
        else if (st_reg == 2'h1)
        begin
            st_reg <= 2'h2;
            o_ack <= 1'b1;
            o_data <= mem_word(addr_reg);
        end
        else if (st_reg == 2'h2 && !(i_mmu.req || i_sysbus.req))
            st_reg <= 2'h0;
    end
endmodule : mpd_mem_model

// >>> verification/mpd_prefetch_dispatch_bench.sv
`timescale 1ns/1ps
module mpd_prefetch_dispatch_bench
    import mpd_pkg::*;
();
    // ----------------------------------------
    // signals and models
    // ----------------------------------------
    logic i_clk = 1'b0, i_reset = 1'b1, i_mmu_fitted = 1'b1, i_cache_fitted = 1'b1;
    logic i_level_change = 1'b0, i_store_req = 1'b0, i_mem_ack, o_uend, o_stall, req_prev;
    mpd_uctl_t i_uctl = '0, u;
    mpd_wcs_t i_wcs = '0;
    mpd_mreq_t o_mmu, o_sysbus;
    logic [UADDR_W-1:0] i_next_uaddr = 12'h000, o_uaddr;
    logic [UWORD_W-1:0] i_rom_word, o_uinst, wcs_v = 64'h0;
    logic [LVL_W-1:0] i_new_level = 4'h0, o_level;
    logic [WORD_W-1:0] i_store_addr = 16'h0000, i_mem_data, o_bus, req_addr, pa, w;
    logic [DISP_W-1:0] o_ir;
    logic [4:0] lat = 5'h00;
    int fail_count = 0, tests_run = 0, req_cnt = 0, ack_cnt = 0, cyc = 0, n0, k;
    wire logic req_any = o_mmu.req | o_sysbus.req;
    function automatic logic [UWORD_W-1:0] rom(input logic [UADDR_W-1:0] a);
        return {4{4'h5, a}};
    endfunction : rom
    function automatic logic [WORD_W-1:0] mem_word(input logic [WORD_W-1:0] a);
        return (a * 16'h0025) ^ 16'h5a3c;
    endfunction : mem_word
    assign i_rom_word = rom(o_uaddr);
    always #12.5 i_clk = ~i_clk;
    mpd_prefetch_dispatch mpd_prefetch_dispatch_inst (
        .i_clk(i_clk), .i_reset(i_reset), .i_mmu_fitted(i_mmu_fitted),
        .i_cache_fitted(i_cache_fitted), .i_uctl(i_uctl), .i_next_uaddr(i_next_uaddr),
        .i_rom_word(i_rom_word), .i_wcs(i_wcs), .i_level_change(i_level_change),
        .i_new_level(i_new_level), .i_store_req(i_store_req), .i_store_addr(i_store_addr),
        .i_mem_ack(i_mem_ack), .i_mem_data(i_mem_data), .o_mmu(o_mmu), .o_sysbus(o_sysbus),
        .o_uaddr(o_uaddr), .o_uinst(o_uinst), .o_uend(o_uend), .o_stall(o_stall),
        .o_ir(o_ir), .o_bus(o_bus), .o_level(o_level));
    mpd_mem_model mpd_mem_model_inst (
        .i_clk(i_clk), .i_reset(i_reset), .i_mmu(o_mmu), .i_sysbus(o_sysbus), .i_lat(lat),
        .o_ack(i_mem_ack), .o_data(i_mem_data));
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string what);
        tests_run++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("BAD %0t %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : check
    task automatic wrap_up();
        if (fail_count == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : wrap_up
    // fetch watcher; the ceiling is far above the few thousand cycles the run needs
    always @(posedge i_clk)
    begin
        cyc <= cyc + 1;
        req_prev <= req_any;
        ack_cnt <= ack_cnt + int'(i_mem_ack === 1'b1);
        if (req_any === 1'b1 && req_prev !== 1'b1)
        begin
            req_cnt <= req_cnt + 1;
            req_addr <= o_mmu.req ? o_mmu.addr : o_sysbus.addr;
            check({o_mmu.req, o_sysbus.req}, {i_mmu_fitted, !i_mmu_fitted}, "route");
        end
        if (cyc == 30000)
        begin
            fail_count++;
            wrap_up();
        end
    end
    // one microinstruction, held until the microcycle end takes it
    task automatic uop(input mpd_uctl_t uu, input logic [UADDR_W-1:0] na);
        logic [UADDR_W-1:0] prev;
        int j;
        @(posedge i_clk);
        i_uctl <= uu;
        i_next_uaddr <= na;
        j = 0;
        do
        begin
            @(posedge i_clk);
            j++;
        end
        while (o_uend !== 1'b1 && j < 40);
        prev = o_uaddr;
        i_uctl <= '0;
        #1;
        if (o_stall === 1'b0)
            check(o_uinst, prev[11] ? wcs_v : rom(prev), "microword");
    endtask : uop
    task automatic wait_req(input logic [WORD_W-1:0] exp);
        int j;
        j = 0;
        while (req_cnt == n0 && j < 100)
        begin
            @(posedge i_clk);
            j++;
        end
        #1;
        check(req_addr, exp, "fetch address");
    endtask : wait_req
    // wait until no access is open, so the prefetch word is known
    task automatic settle();
        int j;
        j = 0;
        repeat (3) @(posedge i_clk);
        while ((ack_cnt != req_cnt || req_any !== 1'b0) && j < 200)
        begin
            @(posedge i_clk);
            j++;
        end
        pa = req_addr;
        w = mem_word(pa);
        n0 = req_cnt;
    endtask : settle
    task automatic dispatch();
        settle();
        u = '0;
        u.next_instr = 1'b1;
        uop(u, 12'($urandom) & 12'h7ff);
        check(o_stall, 1'b0, "stall");
        check(o_ir, w[10:0], "holding register");
        check(o_uaddr, MAP_BASE + UADDR_W'(w[15:11]) * MAP_STRIDE, "map");
        wait_req(pa + 16'h0001);
    endtask : dispatch
    task automatic branch();
        settle();
        u = '0;
        u.src = BS_IR;
        u.dst_pc = 1'b1;
        uop(u, 12'($urandom) & 12'h7ff);
        check(o_bus, {5'h00, o_ir}, "bus word");
        wait_req({5'h00, o_ir});
    endtask : branch
    task automatic store(input logic hit);
        settle();
        @(posedge i_clk);
        i_store_req <= 1'b1;
        i_store_addr <= hit ? pa : pa + 16'h0005;
        @(posedge i_clk);
        i_store_req <= 1'b0;
        if (hit)
            wait_req(pa);
        else
        begin
            repeat (20) @(posedge i_clk);
            check(req_cnt, n0, "needless refetch");
        end
    endtask : store
    task automatic do_reset(input logic fit);
        @(posedge i_clk);
        i_reset <= 1'b1;
        i_mmu_fitted <= fit;
        i_cache_fitted <= fit;
        repeat (7) @(posedge i_clk);
        #1;
        check({o_uend, o_stall, req_any, o_uaddr, o_ir, o_bus, o_level}, '0, "reset state");
        check(o_uinst, '0, "reset microword");
        n0 = req_cnt;
        @(posedge i_clk);
        i_reset <= 1'b0;
        wait_req(RESET_PC);
    endtask : do_reset
    // ----------------------------------------
    // sequence
    // ----------------------------------------
    initial
    begin
        void'($urandom(36383));
        for (int ph = 0; ph < 2; ph++)
        begin
            do_reset(ph == 0);
            while (o_uend !== 1'b1) @(posedge i_clk);
            k = 0;
            do
            begin
                @(posedge i_clk);
                k++;
            end
            while (o_uend !== 1'b1 && k < 20);
            check(k, i_cache_fitted ? UCYC_FAST : UCYC_SLOW, "microcycle");
            // writable store word is run from its address
            wcs_v = {$urandom, $urandom};
            @(posedge i_clk);
            i_wcs <= '{we: 1'b1, addr: 8'h3c, data: wcs_v};
            @(posedge i_clk);
            i_wcs <= '0;
            uop('0, 12'h83c);
            uop('0, 12'h000);
            // register set exchange, then a flushed prefetch
            settle();
            @(posedge i_clk);
            i_level_change <= 1'b1;
            i_new_level <= 4'(ph + 5);
            @(posedge i_clk);
            i_level_change <= 1'b0;
            k = 0;
            while (o_level !== 4'(ph + 5) && k < 30)
            begin
                @(posedge i_clk);
                k++;
            end
            check(k >= 16 && k <= 18, 1'b1, "level exchange time");
            repeat (40) @(posedge i_clk);
            check(req_cnt > n0, 1'b1, "refetch after level change");
            store(1'b1);
            store(1'b0);
            // slow memory: a second start finds the prefetch empty
            lat <= 5'h14;
            dispatch();
            u.next_instr = 1'b1;
            uop(u, 12'h000);
            check({o_stall, o_uinst}, {1'b1, 64'h0}, "stalled start");
            repeat (60) @(posedge i_clk);
            for (int i = 0; i < 30; i++)
            begin
                lat <= 5'($urandom % 8);
                case ($urandom % 4)
                    0: dispatch();
                    1: branch();
                    2: store(1'($urandom));
                    default:
                    begin
                        u = mpd_uctl_t'(22'($urandom));
                        u.src = mpd_src_t'($urandom % 6);
                        {u.dst_pc, u.oper_req, u.next_instr} = 3'h0;
                        uop(u, 12'($urandom) & 12'h7ff);
                    end
                endcase
            end
        end
        wrap_up();
    end
endmodule : mpd_prefetch_dispatch_bench
